// *** logic/pfa_pkg.sv ***
package pfa_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_CONTROL = 6'h01;
  localparam logic [5:0] IDX_ALARM_A_SRC = 6'h0e;
  localparam logic [5:0] IDX_ALARM_B_SRC = 6'h0f;
  localparam logic [5:0] IDX_PIN_FUNC_1 = 6'h10;
  localparam logic [5:0] IDX_PIN_FUNC_2 = 6'h11;
  localparam logic [5:0] IDX_PIN_FUNC_3 = 6'h12;
  localparam logic [5:0] IDX_PIN_FUNC_4 = 6'h13;
  localparam logic [5:0] IDX_PRESET_OPT = 6'h14;

  // ----------------------------------------------------------------
  // Power-on values and writable-bit masks
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_ALARM_SRC = 8'h00;
  localparam logic [7:0] RST_PIN_FUNC_1 = 8'h7f;
  localparam logic [7:0] RST_PIN_FUNC_2 = 8'hce;
  localparam logic [7:0] RST_PIN_FUNC_3 = 8'h42;
  localparam logic [7:0] RST_PIN_FUNC_4 = 8'hfc;
  localparam logic [7:0] RST_PRESET_OPT = 8'h01;
  localparam logic [7:0] WMASK_ALARM_SRC = 8'h1f;
  localparam logic [7:0] WMASK_PIN_FUNC_3 = 8'hfe;
  localparam logic [7:0] WMASK_PIN_FUNC_4 = 8'hfc;
  localparam logic [7:0] WMASK_PRESET_OPT = 8'h1f;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ALM_TIMER_EN = 0;
  localparam int ALM_LOCAL = 1;
  localparam int ALM_REMOTE_LO = 2;
  localparam int PF1_PIN7 = 0;
  localparam int PF1_PIN4 = 1;
  localparam int PF1_DIODE_C = 5;
  localparam int PF1_DIODE_A = 6;
  localparam int PF1_VID = 7;
  localparam int PF2_PIN23_LO = 0;
  localparam int PF2_PIN22 = 2;
  localparam int PF2_PIN21 = 3;
  localparam int PF2_PIN19 = 4;
  localparam int PF2_PIN15 = 5;
  localparam int PF2_PIN13 = 6;
  localparam int PF2_PIN8 = 7;
  localparam int PF3_PIN27 = 1;
  localparam int PF3_PIN26_LO = 2;
  localparam int PF3_PIN25_LO = 4;
  localparam int PF3_PIN24_LO = 6;
  localparam int PF4_PIN32 = 2;
  localparam int PF4_PIN31 = 3;
  localparam int PF4_PIN29_LO = 4;
  localparam int PF4_PIN28_LO = 6;
  localparam int CTL_SOFT_RESET = 0;
  localparam int CTL_LOCK = 1;

  // Two-bit selector codes of pins 28/29
  localparam logic [1:0] SEL_DEFAULT = 2'b00;
  localparam logic [1:0] SEL_ALT_VOLT = 2'b01;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] alarm_a_src;
    logic [7:0] alarm_b_src;
    logic [7:0] pin_func_1;
    logic [7:0] pin_func_2;
    logic [7:0] pin_func_3;
    logic [7:0] pin_func_4;
    logic [7:0] preset_opt;
    logic lock;
  } pfa_cfg_t;

  typedef struct packed {
    logic local_over;
    logic [2:0] remote_over;
  } pfa_temp_t;

  typedef struct packed {
    logic [31:0] out;
    logic [31:0] oe;
  } pfa_pins_t;

endpackage : pfa_pkg

// *** logic/pfa_pin_function_and_alarm_config.sv ***
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
module pfa_pin_function_and_alarm_config #(
  parameter int NUM_PINS = 32
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Temperature comparator results
  input wire pfa_pkg::pfa_temp_t temp_over_a,
  input wire pfa_pkg::pfa_temp_t temp_over_b,
  // Core-side sources for pin drivers
  input wire logic [8:1] general_io_out,
  input wire logic [8:1] general_io_oe,
  input wire logic [4:1] fan_drive_out,
  // Package pins, bit n-1 is pin n
  input wire logic [NUM_PINS-1:0] pin_in,
  output logic [NUM_PINS-1:0] pin_out,
  output logic [NUM_PINS-1:0] pin_oe,
  // Alarm outputs and timer enables
  output logic thermal_alarm_a_n,
  output logic thermal_alarm_b_n,
  output logic alarm_a_timer_en,
  output logic alarm_b_timer_en,
  // Routed inputs towards the core
  output logic [8:1] fan_speed_in,
  output logic [8:1] general_io_in,
  output logic [6:0] voltage_id_inputs,
  output logic chassis_intrusion_in,
  output logic fan_b_full_speed_in,
  output logic regulator_hot_a,
  output logic regulator_hot_b,
  output logic bus_termination_sense_a,
  output logic bus_termination_sense_b,
  // Analog front-end selections
  output logic remote_diode_a_select,
  output logic remote_diode_c_select,
  output logic [1:0] pin23_range,
  output logic [1:0] pin24_range,
  output logic pin19_low_range,
  output logic pin15_low_range,
  output logic [11:0] voltage_input_en,
  output logic [4:0] preset_option
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    pfa_pkg::pfa_cfg_t cfg;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    pfa_pkg::pfa_pins_t pins;
    logic alarm_a_n;
    logic alarm_b_n;
    logic timer_a;
    logic timer_b;
    logic [8:1] fan_speed;
    logic [8:1] gio_in;
    logic [6:0] vid;
    logic intrusion;
    logic fan_b_full;
    logic vr_hot_a;
    logic vr_hot_b;
    logic term_a;
    logic term_b;
    logic diode_a;
    logic diode_c;
    logic [1:0] r23;
    logic [1:0] r24;
    logic r19;
    logic r15;
    logic [11:0] volt_en;
    logic [4:0] preset;
  } pfa_state_t;

  localparam pfa_pkg::pfa_cfg_t CFG_POR = '{
    alarm_a_src: pfa_pkg::RST_ALARM_SRC,
    alarm_b_src: pfa_pkg::RST_ALARM_SRC,
    pin_func_1: pfa_pkg::RST_PIN_FUNC_1,
    pin_func_2: pfa_pkg::RST_PIN_FUNC_2,
    pin_func_3: pfa_pkg::RST_PIN_FUNC_3,
    pin_func_4: pfa_pkg::RST_PIN_FUNC_4,
    preset_opt: pfa_pkg::RST_PRESET_OPT,
    lock: 1'b0
  };

  pfa_state_t state_ff;
  pfa_state_t nxt_state;

  logic [5:0] idx;
  logic aligned;
  logic mapped;
  logic [7:0] rd_byte;
  logic vid_mode;
  logic alarm_a_hit;
  logic alarm_b_hit;
  logic [1:0] sel25;
  logic [1:0] sel26;
  logic [1:0] sel28;
  logic [1:0] sel29;

  assign idx = paddr[7:2];
  assign aligned = (paddr[1:0] == 2'b00);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    pfa_pkg::pfa_cfg_t c;
    logic [7:0] wb;
    c = state_ff.cfg;
    wb = pwdata[7:0];
    nxt_state = state_ff;

    // Address decode and read mux
    mapped = aligned;
    rd_byte = 8'h00;
    unique case (idx)
      pfa_pkg::IDX_CONTROL: rd_byte = {6'h00, c.lock, 1'b0};
      pfa_pkg::IDX_ALARM_A_SRC: rd_byte = c.alarm_a_src;
      pfa_pkg::IDX_ALARM_B_SRC: rd_byte = c.alarm_b_src;
      pfa_pkg::IDX_PIN_FUNC_1: rd_byte = c.pin_func_1;
      pfa_pkg::IDX_PIN_FUNC_2: rd_byte = c.pin_func_2;
      pfa_pkg::IDX_PIN_FUNC_3: rd_byte = c.pin_func_3;
      pfa_pkg::IDX_PIN_FUNC_4: rd_byte = c.pin_func_4;
      pfa_pkg::IDX_PRESET_OPT: rd_byte = c.preset_opt;
      default: mapped = 1'b0;
    endcase

    // Setup phase prepares the answer so pready can come from a flop
    if (psel && !penable) begin
      nxt_state.pready = 1'b1;
      nxt_state.pslverr = !mapped;
      nxt_state.prdata = (mapped && !pwrite) ? {24'h000000, rd_byte} : '0;
    end else begin
      nxt_state.pready = 1'b0;
      nxt_state.pslverr = 1'b0;
    end

    // Writes land at the access edge; a locked set ignores all writes except those to the control register
    if (psel && penable && state_ff.pready && pwrite && mapped) begin
      if (idx == pfa_pkg::IDX_CONTROL) begin
        if (wb[pfa_pkg::CTL_SOFT_RESET]) begin
          c = CFG_POR;
          c.lock = state_ff.cfg.lock;
        end
        if (wb[pfa_pkg::CTL_LOCK]) begin
          c.lock = 1'b1;
        end
      end else if (!c.lock) begin
        unique case (idx)
          pfa_pkg::IDX_ALARM_A_SRC:
            c.alarm_a_src = wb & pfa_pkg::WMASK_ALARM_SRC;
          pfa_pkg::IDX_ALARM_B_SRC:
            c.alarm_b_src = wb & pfa_pkg::WMASK_ALARM_SRC;
          pfa_pkg::IDX_PIN_FUNC_1: c.pin_func_1 = wb;
          pfa_pkg::IDX_PIN_FUNC_2: c.pin_func_2 = wb;
          pfa_pkg::IDX_PIN_FUNC_3:
            c.pin_func_3 = wb & pfa_pkg::WMASK_PIN_FUNC_3;
          pfa_pkg::IDX_PIN_FUNC_4:
            c.pin_func_4 = wb & pfa_pkg::WMASK_PIN_FUNC_4;
          pfa_pkg::IDX_PRESET_OPT:
            c.preset_opt = wb & pfa_pkg::WMASK_PRESET_OPT;
          default: c = c;
        endcase
      end
    end
    nxt_state.cfg = c;

    // ----------------------------------------------------------------
    // Outputs follow the stored configuration one cycle later
    // ----------------------------------------------------------------
    vid_mode = state_ff.cfg.pin_func_1[pfa_pkg::PF1_VID];
    sel25 = state_ff.cfg.pin_func_3[pfa_pkg::PF3_PIN25_LO +: 2];
    sel26 = state_ff.cfg.pin_func_3[pfa_pkg::PF3_PIN26_LO +: 2];
    sel28 = state_ff.cfg.pin_func_4[pfa_pkg::PF4_PIN28_LO +: 2];
    sel29 = state_ff.cfg.pin_func_4[pfa_pkg::PF4_PIN29_LO +: 2];

    nxt_state.timer_a = state_ff.cfg.alarm_a_src[pfa_pkg::ALM_TIMER_EN];
    nxt_state.timer_b = state_ff.cfg.alarm_b_src[pfa_pkg::ALM_TIMER_EN];
    alarm_a_hit = |({temp_over_a.remote_over, temp_over_a.local_over}
      & state_ff.cfg.alarm_a_src[pfa_pkg::ALM_LOCAL +: 4]);
    alarm_b_hit = |({temp_over_b.remote_over, temp_over_b.local_over}
      & state_ff.cfg.alarm_b_src[pfa_pkg::ALM_LOCAL +: 4]);
    nxt_state.alarm_a_n = !alarm_a_hit;
    nxt_state.alarm_b_n = !alarm_b_hit;

    // deselected paths read zero and stop driving
    nxt_state.pins.out = '0;
    nxt_state.pins.oe = '0;
    nxt_state.fan_speed = '0;
    nxt_state.gio_in = '0;
    nxt_state.vid = '0;
    nxt_state.volt_en = '0;

    if (state_ff.cfg.pin_func_1[pfa_pkg::PF1_PIN7]) begin
      nxt_state.fan_speed[5] = pin_in[6];
    end else begin
      nxt_state.volt_en[0] = 1'b1;
    end

    // voltage-ID mode overrides pins 1-4, 28, 31, 32
    if (vid_mode) begin
      nxt_state.vid[3:0] = pin_in[3:0];
      nxt_state.vid[4] = pin_in[30];
      nxt_state.vid[5] = pin_in[31];
      nxt_state.vid[6] = pin_in[27];
    end else begin
      for (int n = 1; n <= 4; n++) begin
        if (state_ff.cfg.pin_func_1[pfa_pkg::PF1_PIN4 + 4 - n]) begin
          nxt_state.fan_speed[n] = pin_in[n-1];
        end else begin
          nxt_state.gio_in[n] = pin_in[n-1];
          nxt_state.pins.out[n-1] = general_io_out[n];
          nxt_state.pins.oe[n-1] = general_io_oe[n];
        end
      end
      if (state_ff.cfg.pin_func_4[pfa_pkg::PF4_PIN32]) begin
        nxt_state.pins.out[31] = fan_drive_out[2];
        nxt_state.pins.oe[31] = 1'b1;
      end else begin
        nxt_state.gio_in[6] = pin_in[31];
        nxt_state.pins.out[31] = general_io_out[6];
        nxt_state.pins.oe[31] = general_io_oe[6];
      end
      if (state_ff.cfg.pin_func_4[pfa_pkg::PF4_PIN31]) begin
        nxt_state.pins.out[30] = fan_drive_out[1];
        nxt_state.pins.oe[30] = 1'b1;
      end else begin
        nxt_state.gio_in[5] = pin_in[30];
        nxt_state.pins.out[30] = general_io_out[5];
        nxt_state.pins.oe[30] = general_io_oe[5];
      end
    end

    // pin 28: general I/O, 1.5 V, or alarm A (open drain)
    // 1.5 V is chosen per pin: sel28 sets pin 28 and sel29 sets pin 29
    if (!vid_mode) begin
      if (sel28 == pfa_pkg::SEL_DEFAULT) begin
        nxt_state.gio_in[7] = pin_in[27];
        nxt_state.pins.out[27] = general_io_out[7];
        nxt_state.pins.oe[27] = general_io_oe[7];
      end else if (sel28 == pfa_pkg::SEL_ALT_VOLT) begin
        nxt_state.volt_en[1] = 1'b1;
      end else begin
        nxt_state.pins.oe[27] = alarm_a_hit;
      end
    end
    // pin 29: general I/O, 1.5 V, or alarm B (open drain)
    if (sel29 == pfa_pkg::SEL_DEFAULT) begin
      nxt_state.gio_in[8] = pin_in[28];
      nxt_state.pins.out[28] = general_io_out[8];
      nxt_state.pins.oe[28] = general_io_oe[8];
    end else if (sel29 == pfa_pkg::SEL_ALT_VOLT) begin
      nxt_state.volt_en[2] = 1'b1;
    end else begin
      nxt_state.pins.oe[28] = alarm_b_hit;
    end
    // Open-drain alarm drive only ever pulls low
    nxt_state.pins.out[27] = nxt_state.pins.oe[27] & (sel28[1] == 1'b0)
      & nxt_state.pins.out[27];
    nxt_state.pins.out[28] = nxt_state.pins.oe[28] & (sel29[1] == 1'b0)
      & nxt_state.pins.out[28];

    if (state_ff.cfg.pin_func_2[pfa_pkg::PF2_PIN22]) begin
      nxt_state.fan_speed[8] = pin_in[21];
    end else begin
      nxt_state.volt_en[3] = 1'b1;
    end
    if (state_ff.cfg.pin_func_2[pfa_pkg::PF2_PIN21]) begin
      nxt_state.fan_speed[7] = pin_in[20];
    end else begin
      nxt_state.volt_en[4] = 1'b1;
    end
    if (state_ff.cfg.pin_func_2[pfa_pkg::PF2_PIN8]) begin
      nxt_state.fan_speed[6] = pin_in[7];
    end else begin
      nxt_state.volt_en[5] = 1'b1;
    end

    if (state_ff.cfg.pin_func_2[pfa_pkg::PF2_PIN13]) begin
      nxt_state.pins.out[12] = fan_drive_out[4];
      nxt_state.pins.oe[12] = 1'b1;
    end else begin
      nxt_state.volt_en[6] = 1'b1;
    end

    // diode inputs or voltage plus termination sense
    nxt_state.diode_c = state_ff.cfg.pin_func_1[pfa_pkg::PF1_DIODE_C];
    nxt_state.diode_a = state_ff.cfg.pin_func_1[pfa_pkg::PF1_DIODE_A];
    nxt_state.term_b = !nxt_state.diode_c & pin_in[19];
    nxt_state.term_a = !nxt_state.diode_a & pin_in[15];
    nxt_state.volt_en[7] = !nxt_state.diode_c;
    nxt_state.volt_en[8] = !nxt_state.diode_a;
    // ranges only mean something with the diode off
    nxt_state.r19 = !nxt_state.diode_c
      & state_ff.cfg.pin_func_2[pfa_pkg::PF2_PIN19];
    nxt_state.r15 = !nxt_state.diode_a
      & state_ff.cfg.pin_func_2[pfa_pkg::PF2_PIN15];

    nxt_state.r23 = state_ff.cfg.pin_func_2[pfa_pkg::PF2_PIN23_LO +: 2];
    nxt_state.r24 = state_ff.cfg.pin_func_3[pfa_pkg::PF3_PIN24_LO +: 2];

    nxt_state.intrusion = state_ff.cfg.pin_func_3[pfa_pkg::PF3_PIN27]
      & pin_in[26];
    nxt_state.fan_b_full = !state_ff.cfg.pin_func_3[pfa_pkg::PF3_PIN27]
      & pin_in[26];

    // pins 26 and 25; codes 10 and 11 both mean regulator hot
    nxt_state.vr_hot_b = sel26[1] & pin_in[25];
    nxt_state.vr_hot_a = sel25[1] & pin_in[24];
    nxt_state.volt_en[9] = !sel26[1];
    nxt_state.volt_en[10] = !sel25[1];
    nxt_state.volt_en[11] = 1'b0;

    nxt_state.preset = state_ff.cfg.preset_opt[4:0];
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= '{
        cfg: CFG_POR,
        prdata: 32'h00000000,
        pins: '{out: 32'h00000000, oe: 32'h00000000},
        alarm_a_n: 1'b1,
        alarm_b_n: 1'b1,
        default: '0
      };
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------
  // Output wiring
  // ----------------------------------------------------------------
  assign prdata = state_ff.prdata;
  assign pready = state_ff.pready;
  assign pslverr = state_ff.pslverr;
  assign pin_out = state_ff.pins.out[NUM_PINS-1:0];
  assign pin_oe = state_ff.pins.oe[NUM_PINS-1:0];
  assign thermal_alarm_a_n = state_ff.alarm_a_n;
  assign thermal_alarm_b_n = state_ff.alarm_b_n;
  assign alarm_a_timer_en = state_ff.timer_a;
  assign alarm_b_timer_en = state_ff.timer_b;
  assign fan_speed_in = state_ff.fan_speed;
  assign general_io_in = state_ff.gio_in;
  assign voltage_id_inputs = state_ff.vid;
  assign chassis_intrusion_in = state_ff.intrusion;
  assign fan_b_full_speed_in = state_ff.fan_b_full;
  assign regulator_hot_a = state_ff.vr_hot_a;
  assign regulator_hot_b = state_ff.vr_hot_b;
  assign bus_termination_sense_a = state_ff.term_a;
  assign bus_termination_sense_b = state_ff.term_b;
  assign remote_diode_a_select = state_ff.diode_a;
  assign remote_diode_c_select = state_ff.diode_c;
  assign pin23_range = state_ff.r23;
  assign pin24_range = state_ff.r24;
  assign pin19_low_range = state_ff.r19;
  assign pin15_low_range = state_ff.r15;
  assign voltage_input_en = state_ff.volt_en;
  assign preset_option = state_ff.preset;

endmodule : pfa_pin_function_and_alarm_config

// *** testbench/pfa_assertions.sv ***
`timescale 1ns/1ps
module pfa_assertions (
  // APB side
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // Alarm side
  input wire pfa_pkg::pfa_temp_t temp_over_a,
  input wire pfa_pkg::pfa_temp_t temp_over_b,
  input wire logic thermal_alarm_a_n,
  input wire logic thermal_alarm_b_n,
  input wire logic alarm_a_timer_en,
  input wire logic alarm_b_timer_en
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  a_err_unmapped: assert property (psel && !penable && paddr == 8'h80
    |=> pslverr && pready) else $error("unmapped access not refused");
  a_alarm_a_idle: assert property (
    temp_over_a == 4'h0 |=> thermal_alarm_a_n)
    else $error("alarm a low with no source over limit");
  a_alarm_b_idle: assert property (
    temp_over_b == 4'h0 |=> thermal_alarm_b_n)
    else $error("alarm b low with no source over limit");
  // Timer enables only move one edge after the access edge of a completed write
  a_timer_a_cause: assert property (
    $changed(alarm_a_timer_en) |-> $past(pwrite, 2) && $past(penable, 2))
    else $error("alarm a timer enable changed without a write");
  a_timer_b_cause: assert property (
    $changed(alarm_b_timer_en) |-> $past(pwrite, 2) && $past(penable, 2))
    else $error("alarm b timer enable changed without a write");
endmodule : pfa_assertions

// *** testbench/pfa_testbench.sv ***
`timescale 1ns/1ps
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  pfa_pkg::pfa_temp_t temp_over_a = 4'h0;
  pfa_pkg::pfa_temp_t temp_over_b = 4'h0;
  logic [8:1] general_io_out = 8'h5a;
  logic [8:1] general_io_oe = 8'hff;
  logic [4:1] fan_drive_out = 4'ha;
  // Every pin high so a routed input shows 1 only when selected
  logic [31:0] pin_in = 32'hffffffff;
  logic [31:0] pin_out;
  logic [31:0] pin_oe;
  logic thermal_alarm_a_n;
  logic thermal_alarm_b_n;
  logic alarm_a_timer_en;
  logic alarm_b_timer_en;
  logic [8:1] fan_speed_in;
  logic [8:1] general_io_in;
  logic [6:0] voltage_id_inputs;
  logic chassis_intrusion_in;
  logic fan_b_full_speed_in;
  logic regulator_hot_a;
  logic regulator_hot_b;
  logic bus_termination_sense_a;
  logic bus_termination_sense_b;
  logic remote_diode_a_select;
  logic remote_diode_c_select;
  logic [1:0] pin23_range;
  logic [1:0] pin24_range;
  logic pin19_low_range;
  logic pin15_low_range;
  logic [11:0] voltage_input_en;
  logic [4:0] preset_option;
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [7:0] r;
  logic e;
  logic [7:0] por [7] = '{8'h00, 8'h00, 8'h7f, 8'hce, 8'h42, 8'hfc, 8'h01};
  logic [7:0] msk [7] = '{8'h1f, 8'h1f, 8'hff, 8'hff, 8'hfe, 8'hfc, 8'h1f};

  always #20 pclk = ~pclk;

  pfa_pin_function_and_alarm_config dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .temp_over_a,
    .temp_over_b, .general_io_out, .general_io_oe, .fan_drive_out, .pin_in,
    .pin_out, .pin_oe, .thermal_alarm_a_n, .thermal_alarm_b_n,
    .alarm_a_timer_en, .alarm_b_timer_en, .fan_speed_in, .general_io_in,
    .voltage_id_inputs, .chassis_intrusion_in, .fan_b_full_speed_in,
    .regulator_hot_a, .regulator_hot_b, .bus_termination_sense_a,
    .bus_termination_sense_b, .remote_diode_a_select, .remote_diode_c_select,
    .pin23_range, .pin24_range, .pin19_low_range, .pin15_low_range,
    .voltage_input_en, .preset_option);

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checks_done++;
    if (s !== x) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, s, x);
    end
  endtask : chk

  // Request stands until pready is seen at a rising edge; the answer is
  // taken at that same edge and only then is the request released
  task automatic apb(input logic w, input logic [5:0] i, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {i, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    // Zero wait states: the answer stands in the first access cycle
    chk(n, 1);
    r = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [5:0] i, input logic [7:0] x);
    apb(1'b0, i, 8'h00);
    chk({e, r}, {1'b0, x});
  endtask : rd

  // One extra edge lets the derived outputs follow the new setting
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    apb(1'b1, i, d);
    @(posedge pclk);
    #1;
  endtask : wr

  task automatic tmp(input int a, input logic [3:0] v);
    @(posedge pclk);
    if (a != 0) temp_over_b <= v;
    else temp_over_a <= v;
    repeat (2) @(posedge pclk);
    #1;
  endtask : tmp

  task automatic summarize;
    $display("mismatches %0d, checks %0d", bad_count, checks_done);
    if (bad_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 4000) begin
      bad_count++;
      summarize();
    end
  end

  // --------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------
  initial begin
    logic [3:0] m;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 7; i++) rd(6'h0e + 6'(i), por[i]);
    for (int i = 0; i < 7; i++) begin
      wr(6'h0e + 6'(i), 8'hff);
      rd(6'h0e + 6'(i), msk[i]);
    end
    wr(pfa_pkg::IDX_CONTROL, 8'h01);
    for (int i = 0; i < 7; i++) rd(6'h0e + 6'(i), por[i]);
    apb(1'b0, 6'h20, 8'h00);
    chk(e, 1'b1);
    chk(fan_speed_in, 8'hff);
    chk(voltage_input_en, 12'h600);
    chk({remote_diode_a_select, remote_diode_c_select,
      chassis_intrusion_in, pin23_range, pin24_range}, 7'h79);
    chk({pin_oe[12], pin_out[12], preset_option}, 7'h61);
    wr(pfa_pkg::IDX_PIN_FUNC_1, 8'h00);
    chk({fan_speed_in, general_io_in}, 16'he00f);
    chk(voltage_input_en, 12'h781);
    chk({remote_diode_a_select, remote_diode_c_select,
      bus_termination_sense_a, bus_termination_sense_b}, 4'h3);
    wr(pfa_pkg::IDX_PIN_FUNC_1, 8'h80);
    chk({voltage_id_inputs, general_io_in}, 15'h7f00);
    chk(pin_oe[3:0], 4'h0);
    wr(pfa_pkg::IDX_PIN_FUNC_2, 8'h31);
    chk({pin23_range, pin19_low_range, pin15_low_range, fan_speed_in},
      12'h700);
    chk(pin_oe[12], 1'b0);
    wr(pfa_pkg::IDX_PIN_FUNC_3, 8'he8);
    chk({fan_b_full_speed_in, chassis_intrusion_in, regulator_hot_a,
      regulator_hot_b, pin24_range}, 6'h2f);
    wr(pfa_pkg::IDX_PIN_FUNC_4, 8'h00);
    chk(general_io_in, 8'h80);
    wr(pfa_pkg::IDX_PIN_FUNC_1, 8'h00);
    chk(general_io_in, 8'hff);
    chk({pin_oe[31:27], pin_out[31:27], pin_oe[3:0], pin_out[3:0]},
      18'h369fa);
    // software sets 1.5 V on both paired pins together
    wr(pfa_pkg::IDX_PIN_FUNC_4, 8'h5c);
    chk({voltage_input_en[2:1], pin_oe[28:27]}, 4'hc);
    wr(pfa_pkg::IDX_PIN_FUNC_4, 8'hfc);
    chk({pin_oe[31:30], pin_out[31:30]}, 4'he);
    for (int a = 0; a < 2; a++) begin
      for (int b = 1; b < 5; b++) begin
        m = (b == 1) ? 4'h8 : 4'(4'h1 << (b - 2));
        wr(6'h0e + 6'(a), 8'h01 | 8'(8'h01 << b));
        tmp(a, ~m);
        chk({(a ? thermal_alarm_b_n : thermal_alarm_a_n),
          pin_oe[27 + a]}, 2'h2);
        tmp(a, m);
        chk(a ? thermal_alarm_b_n : thermal_alarm_a_n, 1'b0);
        chk({pin_oe[27 + a], pin_out[27 + a],
          a ? alarm_b_timer_en : alarm_a_timer_en}, 3'h5);
        tmp(a, 4'h0);
      end
    end
    // Lock holds until a hardware reset, which is tried mid-run
    wr(pfa_pkg::IDX_CONTROL, 8'h02);
    rd(pfa_pkg::IDX_CONTROL, 8'h02);
    wr(pfa_pkg::IDX_PIN_FUNC_2, 8'h00);
    rd(pfa_pkg::IDX_PIN_FUNC_2, 8'h31);
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    rd(pfa_pkg::IDX_PIN_FUNC_2, 8'hce);
    rd(pfa_pkg::IDX_CONTROL, 8'h00);
    summarize();
  end
endmodule : testbench

bind pfa_pin_function_and_alarm_config pfa_assertions chk_i (.pclk,
  .presetn, .psel, .penable, .pwrite, .paddr, .pready, .pslverr,
  .temp_over_a, .temp_over_b, .thermal_alarm_a_n, .thermal_alarm_b_n,
  .alarm_a_timer_en, .alarm_b_timer_en);
